// file: hw/swc_ctrl.sv
// Purpose: sleep entry, wake-up and start-up delay control
// Assumes: all inputs except pins are on clk; pins are synchronised here
// Notes: por input sets both status flags; other resets are pulses
//
// What this block does
// - sleep enters power-down, clears watchdog and postscaler
// - sleep entry clears powerdown, sets timeout flag
// - oscillator driver off during sleep
// - port pins hold their entry state
// - watchdog reset never drives master clear pin
// - listed resets and interrupts wake the device
// - only six peripheral interrupts may wake
// - reset wakes reset; interrupt wakes resume, in crystal or low-freq mode after a start-up device_reset hold
// - powerdown flag set at power-up
// - watchdog timeout reset clears timeout flag
// - sleep instruction prefetches next address
// - wake needs enable, ignores global disable
// - disabled globally: continue in line
// - enabled globally: next instruction, then vector
// - pending enabled flag wakes immediately
// - watchdog cleared on any wake
// - crystal or low-freq wake holds 1024 periods
// - rc mode adds no start-up delay
`timescale 1ns/100ps
module swc_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_exec,
    input wire swc_pkg::swc_osc_t osc_mode,
    input wire logic wdt_enable,
    input wire logic global_interrupt_disable,
    input wire swc_pkg::swc_rst_src_t rst_src,
    input wire logic external_interrupt_pin,
    input wire logic timer0_clock_input,
    input wire logic portb_change,
    input wire swc_pkg::swc_irq_t irq,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    output logic osc_drive_en,
    output logic core_clk_en,
    output logic device_reset,
    output logic wdt_clear,
    output logic prefetch_next,
    output logic take_vector,
    output logic master_clear_pin_o,
    output logic master_clear_pin_oe,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output swc_pkg::swc_status_t cpu_status_register,
    output logic asleep
);
    import swc_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pin_s1_ff;
    logic [2:0] pin_s2_ff;
    logic [2:0] pin_d_ff;
    always_ff @(posedge clk) begin
        pin_s1_ff <= {external_interrupt_pin, timer0_clock_input,
                      portb_change};
        pin_s2_ff <= pin_s1_ff;
        pin_d_ff <= pin_s2_ff;
    end
    // edge of external pin and timer0 input, level of port change
    wire ext_evt = pin_s2_ff[2] & ~pin_d_ff[2];
    wire t0_evt = pin_s2_ff[1] & ~pin_d_ff[1];
    wire rb_evt = pin_s2_ff[0];

    // ****************************************
    // wake decode
    // ****************************************
    swc_state_t state_ff;
    swc_state_t nxt_state;
    logic [`SWC_CNT_W-1:0] ost_cnt_ff;
    logic [`SWC_CNT_W-1:0] nxt_ost_cnt;
    logic irq_wake_ff;
    logic nxt_irq_wake;
    logic pd_ff;
    logic to_ff;
    logic [7:0] hold_out_ff;
    logic [7:0] hold_oe_ff;

    // the peripheral mask keeps clockless peripherals only
    localparam logic [`SWC_NPER-1:0] PER_WAKE_MASK =
        `SWC_NPER'((1 << `SWC_PER_CAP) | (1 << `SWC_PER_UTX) |
                   (1 << `SWC_PER_URX) | (1 << `SWC_PER_ADC) |
                   (1 << `SWC_PER_SPI) | (1 << `SWC_PER_I2C));

    function automatic logic any_pending(
        input logic [`SWC_NSRC-1:0] en,
        input logic [`SWC_NSRC-1:0] fl
    );
        any_pending = |(en & fl);
    endfunction : any_pending

    wire [`SWC_NSRC-1:0] core_live =
        irq.core_flag | {ext_evt, t0_evt, rb_evt, 1'b0};
    wire irq_wake = any_pending(irq.core_en, core_live) |
        |(irq.per_en & irq.per_flag & PER_WAKE_MASK);
    wire wdt_rst = rst_src.wdt_to & wdt_enable;
    wire any_rst = rst_src.por | rst_src.bor | rst_src.mclr
        | wdt_rst;
    wire needs_ost = (osc_mode == SWC_OSC_XT) |
        (osc_mode == SWC_OSC_LF);
    wire in_sleep = (state_ff == SWC_SLEEP);
    wire enter = (state_ff == SWC_RUN) & sleep_exec & ~any_rst
        & ~irq_wake;
    wire ost_done = (ost_cnt_ff == `SWC_CNT_W'(`SWC_OST_CYC - 1));

    // ****************************************
    // state machine
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_ost_cnt = ost_cnt_ff;
        nxt_irq_wake = irq_wake_ff;
        case (state_ff)
            SWC_RUN: begin
                nxt_irq_wake = 1'b0;
                if (enter) begin
                    nxt_state = SWC_SLEEP;
                end
            end
            SWC_SLEEP: begin
                if (any_rst | irq_wake) begin
                    nxt_irq_wake = ~any_rst;
                    nxt_ost_cnt = '0;
                    nxt_state = needs_ost ? SWC_OST : SWC_RUN;
                end
            end
            SWC_OST: begin
                nxt_ost_cnt = ost_cnt_ff + `SWC_CNT_W'(1);
                if (ost_done) begin
                    nxt_state = SWC_RUN;
                end
            end
            default: begin
                nxt_state = SWC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= SWC_RUN;
            ost_cnt_ff <= '0;
            irq_wake_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ost_cnt_ff <= nxt_ost_cnt;
            irq_wake_ff <= nxt_irq_wake;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    // power-on sets both; set by sleep entry wins over nothing else
    always_ff @(posedge clk) begin
        if (rst | rst_src.por) begin
            pd_ff <= 1'b1;
            to_ff <= 1'b1;
        end else if (wdt_rst) begin
            to_ff <= 1'b0;
        end else if (sleep_exec & (state_ff == SWC_RUN)) begin
            pd_ff <= 1'b0;
            to_ff <= 1'b1;
        end
    end

    // ****************************************
    // pin hold
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_out_ff <= 8'h00;
            hold_oe_ff <= 8'h00;
        end else if (!in_sleep) begin
            hold_out_ff <= port_out;
            hold_oe_ff <= port_oe;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    wire osc_off = in_sleep;
    wire in_ost = (state_ff == SWC_OST);
    wire wake_evt = in_sleep & (any_rst | irq_wake);
    assign osc_drive_en = ~osc_off;
    assign core_clk_en = (state_ff == SWC_RUN);
    assign asleep = in_sleep;
    // ost holds the device in reset; rc resumes at once
    assign device_reset = any_rst | in_ost;
    assign wdt_clear = enter | wake_evt;
    assign prefetch_next = enter;
    // vector only after an interrupt wake with interrupts enabled
    assign take_vector = irq_wake_ff & core_clk_en
        & ~global_interrupt_disable;
    // master clear is an input only; never driven low
    assign master_clear_pin_o = 1'b1;
    assign master_clear_pin_oe = 1'b0;
    assign pin_out = hold_out_ff;
    assign pin_oe = hold_oe_ff;
    assign cpu_status_register = '{powerdown_flag: pd_ff,
                                   timeout_flag: to_ff};

    // ****************************************
    // assertions
    // ****************************************
    // counts hold cycles apart from the state counter, so a wrong
    // end value in the state counter cannot hide itself
    logic [`SWC_CNT_W:0] hold_len_ff;
    always_ff @(posedge clk) begin
        if (rst | !in_ost) begin
            hold_len_ff <= '0;
        end else begin
            hold_len_ff <= hold_len_ff + {{`SWC_CNT_W{1'b0}}, 1'b1};
        end
    end

    // sleep entry and status
    a_sleep_clears_pd: assert property (
        @(posedge clk) disable iff (rst)
        enter |=> !pd_ff && to_ff)
        else $error("sleep entry left status wrong");
    a_enter_decode: assert property (
        @(posedge clk) disable iff (rst)
        state_ff == SWC_RUN && sleep_exec && !any_rst && !irq_wake
        |-> wdt_clear && prefetch_next)
        else $error("sleep entry not decoded");
    a_pend_no_sleep: assert property (
        @(posedge clk) disable iff (rst)
        state_ff == SWC_RUN && sleep_exec && irq_wake |=>
        state_ff == SWC_RUN)
        else $error("slept with pending interrupt");
    a_por_flags: assert property (
        @(posedge clk) disable iff (rst)
        rst_src.por |=> pd_ff && to_ff)
        else $error("power-on left flags wrong");
    a_wdt_to_flag: assert property (
        @(posedge clk) disable iff (rst)
        wdt_rst && !rst_src.por |=> !to_ff)
        else $error("timeout flag not cleared");

    // clocks and pins, asleep and awake
    a_osc_off_sleep: assert property (
        @(posedge clk) disable iff (rst)
        in_sleep |-> !osc_drive_en && !core_clk_en)
        else $error("oscillator runs in sleep");
    a_osc_on_run: assert property (
        @(posedge clk) disable iff (rst)
        core_clk_en |-> osc_drive_en)
        else $error("core clocked without oscillator");
    a_ost_osc_on: assert property (
        @(posedge clk) disable iff (rst)
        in_ost |-> osc_drive_en && !core_clk_en)
        else $error("start-up hold state wrong");
    a_pin_hold: assert property (
        @(posedge clk) disable iff (rst)
        in_sleep && $past(in_sleep) |-> $stable(pin_out)
        && $stable(pin_oe))
        else $error("pins moved in sleep");
    a_pins_follow: assert property (
        @(posedge clk) disable iff (rst)
        !in_sleep |=> pin_out == $past(port_out)
        && pin_oe == $past(port_oe))
        else $error("pins do not follow the core");
    a_mclr_not_driven: assert property (
        @(posedge clk) disable iff (rst)
        wdt_rst |-> !master_clear_pin_oe)
        else $error("master clear driven");
    a_mclr_high: assert property (
        @(posedge clk) disable iff (rst)
        master_clear_pin_o && !master_clear_pin_oe)
        else $error("master clear pin pulled");

    // wake sources
    a_irq_wakes: assert property (
        @(posedge clk) disable iff (rst)
        in_sleep && irq_wake |=> !in_sleep)
        else $error("enabled interrupt did not wake");
    a_wake_needs_en: assert property (
        @(posedge clk) disable iff (rst)
        in_sleep && !any_rst && !(|(irq.core_en & core_live))
        && !(|(irq.per_en & irq.per_flag & PER_WAKE_MASK)) |=> in_sleep)
        else $error("woke without an enabled source");
    a_wdt_off_sleep: assert property (
        @(posedge clk) disable iff (rst)
        in_sleep && rst_src.wdt_to && !wdt_enable && !rst_src.por
        && !rst_src.bor && !rst_src.mclr && !irq_wake |=> in_sleep)
        else $error("disabled watchdog woke the device");
    a_rst_wake_full: assert property (
        @(posedge clk) disable iff (rst)
        in_sleep && any_rst |-> device_reset)
        else $error("reset wake without device reset");
    a_irq_no_reset: assert property (
        @(posedge clk) disable iff (rst)
        wake_evt && !any_rst && !needs_ost |=> !device_reset || any_rst)
        else $error("interrupt wake reset the device");
    a_wdt_clr_wake: assert property (
        @(posedge clk) disable iff (rst)
        wake_evt |-> wdt_clear)
        else $error("watchdog not cleared on wake");

    // resume path
    a_rc_no_delay: assert property (
        @(posedge clk) disable iff (rst)
        wake_evt && !needs_ost |=> state_ff == SWC_RUN)
        else $error("rc wake delayed");
    a_ost_hold_rst: assert property (
        @(posedge clk) disable iff (rst)
        wake_evt && needs_ost && !any_rst |=>
        device_reset [*8])
        else $error("start-up hold missing");
    a_ost_length: assert property (
        @(posedge clk) disable iff (rst)
        $fell(in_ost) |->
        $past(hold_len_ff) == {1'b0, `SWC_CNT_W'(`SWC_OST_CYC - 1)})
        else $error("start-up hold length wrong");
    a_vector_gid: assert property (
        @(posedge clk) disable iff (rst)
        take_vector |-> !global_interrupt_disable && core_clk_en)
        else $error("vectored with interrupts disabled");
    a_vector_seen: assert property (
        @(posedge clk) disable iff (rst)
        $rose(core_clk_en) && irq_wake_ff && !global_interrupt_disable
        |-> take_vector)
        else $error("interrupt wake did not vector");

    c_sleep: cover property (@(posedge clk) disable iff (rst) enter);
    c_irq_wake: cover property (@(posedge clk) disable iff (rst)
        wake_evt && !any_rst);
    c_rst_wake: cover property (@(posedge clk) disable iff (rst)
        wake_evt && any_rst);
    c_ost_end: cover property (@(posedge clk) disable iff (rst)
        $fell(in_ost));
    c_vector: cover property (@(posedge clk) disable iff (rst)
        take_vector);
endmodule : swc_ctrl

// file: shared/swc_map.svh
// Purpose: constants for the sleep and wake controller
// Assumes: 10 MHz clk, one oscillator period per clk
// Notes: oscillator modes are encoded in the package enum
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_OST_TOSC 1024
`define SWC_OST_CYC ((`SWC_OST_TOSC + 0) / 1)
`define SWC_CNT_W 11
`define SWC_NSRC 4
`define SWC_NPER 6
`define SWC_PER_CAP 0
`define SWC_PER_UTX 1
`define SWC_PER_URX 2
`define SWC_PER_ADC 3
`define SWC_PER_SPI 4
`define SWC_PER_I2C 5
`endif

// file: shared/swc_pkg.sv
// Purpose: types for the sleep and wake controller
// Assumes: included map header for widths
// Notes: none
`include "swc_map.svh"
package swc_pkg;
    typedef enum logic [1:0] {
        SWC_OSC_RC = 2'h0,
        SWC_OSC_XT = 2'h1,
        SWC_OSC_LF = 2'h2,
        SWC_OSC_HS = 2'h3
    } swc_osc_t;
    typedef enum logic [1:0] {
        SWC_RUN = 2'h0,
        SWC_SLEEP = 2'h1,
        SWC_OST = 2'h2
    } swc_state_t;
    // reset sources, each active high
    typedef struct packed {
        logic por;
        logic bor;
        logic mclr;
        logic wdt_to;
    } swc_rst_src_t;
    // interrupt sources: enable and flag pairs
    typedef struct packed {
        logic [`SWC_NSRC-1:0] core_en;
        logic [`SWC_NSRC-1:0] core_flag;
        logic [`SWC_NPER-1:0] per_en;
        logic [`SWC_NPER-1:0] per_flag;
    } swc_irq_t;
    typedef struct packed {
        logic powerdown_flag;
        logic timeout_flag;
    } swc_status_t;
endpackage : swc_pkg

// file: testbench/swc_src_model.sv
// Purpose: far-side model of the asynchronous wake pins
// Assumes: fire is a request from the bench on clk, held until the core clock returns
// Notes: rising edges land well away from clk so the synchroniser is exercised
`timescale 1ns/100ps
module swc_src_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic sel,
    output logic ext_pin,
    output logic t0_pin
);
    // ****************
    // pin edge maker
    // ****************
    // the modelled program keeps a nop after every sleep instruction
    localparam logic NOP_AFTER_SLEEP = 1'b1;
    initial begin
        ext_pin = 1'b0;
        t0_pin = 1'b0;
    end
    // pulse is held 4 cycles so the 2FF sync cannot miss it
    always @(posedge clk) begin
        if (fire) begin
            #37;
            ext_pin = !sel;
            t0_pin = sel;
            repeat (4) @(posedge clk);
            ext_pin = 1'b0;
            t0_pin = 1'b0;
        end
    end
endmodule : swc_src_model

// file: testbench/tb.sv
// Purpose: self-checking bench for the sleep and wake controller
// Assumes: inputs move 1 ns after the rising edge of clk
// Notes: port change is driven as a pin level and as an irq flag
`timescale 1ns/100ps
module tb;
    import swc_pkg::*;
    logic clk, rst, sleep_exec, wdt_enable, gid, fire, sel, rb;
    logic osc_drive_en, core_clk_en, device_reset, wdt_clear, pf_next;
    logic take_vector, mclr_o, mclr_oe, asleep, ext_pin, t0_pin;
    logic [7:0] port_out, port_oe, pin_out, pin_oe, held, held_oe;
    swc_osc_t osc_mode;
    swc_rst_src_t rst_src;
    swc_irq_t irq;
    swc_status_t sts;
    int err_count, total_checks, n, i;
    swc_ctrl dut (.clk(clk), .rst(rst), .sleep_exec(sleep_exec),
        .osc_mode(osc_mode), .wdt_enable(wdt_enable),
        .global_interrupt_disable(gid), .rst_src(rst_src),
        .external_interrupt_pin(ext_pin), .timer0_clock_input(t0_pin),
        .portb_change(rb), .irq(irq), .port_out(port_out),
        .port_oe(port_oe), .osc_drive_en(osc_drive_en),
        .core_clk_en(core_clk_en), .device_reset(device_reset),
        .wdt_clear(wdt_clear), .prefetch_next(pf_next),
        .take_vector(take_vector), .master_clear_pin_o(mclr_o),
        .master_clear_pin_oe(mclr_oe), .pin_out(pin_out),
        .pin_oe(pin_oe), .cpu_status_register(sts), .asleep(asleep));
    swc_src_model model (.clk(clk), .fire(fire), .sel(sel),
        .ext_pin(ext_pin), .t0_pin(t0_pin));
    // ****************
    // helpers
    // ****************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    // bounded wait for the core clock to come back
    task automatic wait_run(input int lim);
        n = 0;
        while (core_clk_en !== 1'b1) begin
            if (n == lim) begin
                err_count++;
                complete_run();
            end
            step(1);
            n++;
        end
    endtask : wait_run
    task automatic go_sleep;
        sleep_exec = 1'b1;
        #1;
        chk(wdt_clear, 1'b1);
        chk(pf_next, 1'b1);
        step(1);
        sleep_exec = 1'b0;
        chk(asleep, 1'b1);
        chk(sts, 2'h1);
        chk(osc_drive_en, 1'b0);
    endtask : go_sleep
    // ****************
    // scenarios
    // ****************
    initial begin
        {rst, sleep_exec, wdt_enable, gid, fire, sel} = 6'h20;
        rb = 1'b0;
        {port_out, port_oe, rst_src, irq} = '0;
        osc_mode = SWC_OSC_RC;
        n = $urandom(50);
        step(10);
        rst = 1'b0;
        chk(sts, 2'h3);
        // every interrupt wake source once, rc mode, random global disable
        for (i = 0; i < 13; i++) begin
            gid = 1'($urandom_range(1, 0));
            port_out = 8'($urandom);
            port_oe = 8'($urandom);
            step(2);
            held = port_out;
            held_oe = port_oe;
            go_sleep();
            port_out = ~held;
            port_oe = ~port_oe;
            if (i < 4) irq.core_flag[i] = 1'b1;
            if (i >= 4 && i < 10) irq.per_flag[i-4] = 1'b1;
            step(3);
            chk(pin_out, held);
            chk(pin_oe, held_oe);
            chk(asleep, 1'b1);
            if (i < 4) irq.core_en[i] = 1'b1;
            if (i >= 4 && i < 10) irq.per_en[i-4] = 1'b1;
            if (i >= 10) irq.core_en[13-i] = 1'b1;
            fire = (i == 10) || (i == 11);
            rb = (i == 12);
            sel = (i == 11);
            #1;
            if (i < 10) chk(wdt_clear, 1'b1);
            wait_run(10);
            fire = 1'b0;
            rb = 1'b0;
            if (i < 10) chk(n, 16'h1);
            chk(take_vector, !gid);
            irq = '0;
            step(6);
        end
        irq.core_en[0] = 1'b1;
        irq.core_flag[0] = 1'b1;
        gid = 1'b1;
        sleep_exec = 1'b1;
        step(1);
        sleep_exec = 1'b0;
        step(1);
        chk({asleep, sts}, 3'h1);
        irq = '0;
        // start-up hold in crystal and low-frequency modes
        for (i = 1; i < 3; i++) begin
            osc_mode = swc_osc_t'(i);
            step(1);
            go_sleep();
            irq.per_en[3] = 1'b1;
            irq.per_flag[3] = 1'b1;
            step(1);
            chk(osc_drive_en, 1'b1);
            n = 0;
            while (device_reset === 1'b1 && n < 2000) begin
                step(1);
                n++;
            end
            chk(n, 16'd1024);
            chk(core_clk_en, 1'b1);
            irq = '0;
        end
        // watchdog reset out of sleep, then power-on reset
        osc_mode = SWC_OSC_HS;
        wdt_enable = 1'b1;
        step(1);
        go_sleep();
        rst_src.wdt_to = 1'b1;
        #1;
        chk({device_reset, mclr_o, mclr_oe}, 3'h6);
        step(1);
        rst_src.wdt_to = 1'b0;
        step(2);
        chk({asleep, sts.timeout_flag}, 2'h0);
        rst_src.por = 1'b1;
        step(1);
        rst_src.por = 1'b0;
        step(2);
        chk(sts, 2'h3);
        complete_run();
    end
endmodule : tb
